// ---- src/sdmr5_map.svh ----
// sdmr5_map.svh: field positions, codes and reset values of the inversion/mask/parity mode register
// assumes inclusion by the package and the link and core modules
`ifndef SDMR5_MAP_SVH
`define SDMR5_MAP_SVH
`define SDMR5_WORD_W 22
`define SDMR5_REG_W 18
`define SDMR5_SEL_HI 20
`define SDMR5_SEL_LO 18
`define SDMR5_SEL_OPT 3'h5
`define SDMR5_SEL_PREV 3'h4
`define SDMR5_B_RD_INV 12
`define SDMR5_B_WR_INV 11
`define SDMR5_B_MASK 10
`define SDMR5_B_PERSIST 9
`define SDMR5_PARK_HI 8
`define SDMR5_PARK_LO 6
`define SDMR5_B_TBUF 5
`define SDMR5_B_PERR 4
`define SDMR5_B_CERR 3
`define SDMR5_PLAT_HI 2
`define SDMR5_PLAT_LO 0
`define SDMR5_P_TRAIN 10
`define SDMR5_CAL_HI 8
`define SDMR5_CAL_LO 6
`define SDMR5_P_VREF 4
`define SDMR5_P_TCR 3
`define SDMR5_P_TRNG 2
`define SDMR5_P_SAVE 1
`define SDMR5_OPT_RESET 18'h00000
`define SDMR5_WRITABLE 18'h01FE7
`define SDMR5_CAL_MAX 8
`endif

// ---- src/sdmr5_pkg.sv ----
// sdmr5_pkg: types shared by the mode register block
// assumes the map header sits on the include path
`include "sdmr5_map.svh"
package sdmr5_pkg;
   typedef logic [`SDMR5_WORD_W-1:0] sdmr5_word_t;
   typedef logic [`SDMR5_REG_W-1:0] sdmr5_reg_t;
   typedef enum logic [1:0] {
      SDMR5_PIN_NONE = 2'h0,
      SDMR5_PIN_MASK = 2'h1,
      SDMR5_PIN_INV = 2'h2,
      SDMR5_PIN_TSTRB = 2'h3
   } sdmr5_pin_t;
   typedef enum logic [1:0] {
      SDMR5_LK_RUN = 2'h1,
      SDMR5_LK_SAVE = 2'h2
   } sdmr5_lk_t;
endpackage

// ---- src/sdmr5_xfer_if.sv ----
// sdmr5_xfer_if: carries a taken mode register word from link to core
// assumes word is stable whenever toggle has changed
`timescale 1ns/1ps
`default_nettype none
interface sdmr5_xfer_if import sdmr5_pkg::*; ();
   sdmr5_word_t word;
   logic tgl;
   logic save;
   modport link (output word, output tgl, output save);
   modport core (input word, input tgl, input save);
endinterface
`default_nettype wire

// ---- src/sdmr5_sync.sv ----
// sdmr5_sync: multi-stage level synchroniser, bits independent
// assumes each bit is a slow level or a toggle
`timescale 1ns/1ps
`default_nettype none
module sdmr5_sync #(
   parameter int WIDTH = 1,
   parameter int STAGES = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   typedef struct packed {
      logic [STAGES-1:0][WIDTH-1:0] st;
   } sdmr5_sync_t;
   sdmr5_sync_t s_ff, nxt_s;
   initial begin
      if (STAGES < 2 || WIDTH < 1) begin
         $error("sdmr5_sync: need two stages and one bit");
      end
   end
   always_comb begin
      nxt_s = s_ff;
      nxt_s.st[0] = d;
      for (int i = 1; i < STAGES; i++) begin
         nxt_s.st[i] = s_ff.st[i-1];
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end
   assign q = s_ff.st[STAGES-1];
endmodule
`default_nettype wire

// ---- src/sdmr5_link.sv ----
// sdmr5_link: command clock side; takes mode register set, applies latency and save mode
// assumes pins change synchronously to the command clock
`timescale 1ns/1ps
`default_nettype none
`include "sdmr5_map.svh"
module sdmr5_link import sdmr5_pkg::*; #(
   parameter int CAL_DEPTH = `SDMR5_CAL_MAX
) (
   input wire logic ck,
   input wire logic rst_n,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic act_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [3:0] bgba,
   input wire logic [17:0] addr,
   sdmr5_xfer_if.link xf
);
   typedef struct packed {
      logic cke;
      logic cs;
      logic mode_register_set_cmd;
      sdmr5_word_t w;
      logic [CAL_DEPTH-1:0] cs_line;
      logic [2:0] cal;
      sdmr5_lk_t st;
      sdmr5_word_t out;
      logic tgl;
   } sdmr5_lk_st_t;
   sdmr5_lk_st_t s_ff, nxt_s;
   logic take;
   initial begin
      if (CAL_DEPTH < `SDMR5_CAL_MAX) begin
         $error("sdmr5_link: latency line too short");
      end
   end
   function automatic logic [3:0] cal_clocks(input logic [2:0] c);
      case (c)
         3'h1: cal_clocks = 4'h3;
         3'h2: cal_clocks = 4'h4;
         3'h3: cal_clocks = 4'h5;
         3'h4: cal_clocks = 4'h6;
         3'h5: cal_clocks = 4'h8;
         default: cal_clocks = 4'h0;
      endcase
   endfunction
   always_comb begin
      logic [3:0] n;
      n = cal_clocks(s_ff.cal);
      nxt_s = s_ff;
      nxt_s.cke = cke;
      nxt_s.cs = !cs_n;
      nxt_s.mode_register_set_cmd = act_n && !ras_n && !cas_n && !we_n;
      nxt_s.w = {bgba, addr[17], 3'h0, addr[13:0]};
      nxt_s.cs_line = {s_ff.cs_line[CAL_DEPTH-2:0], s_ff.cs};
      take = (n == 4'h0) ? s_ff.cs : s_ff.cs_line[3'(n - 4'h1)];
      case (s_ff.st)
         SDMR5_LK_SAVE: begin
            if (s_ff.cke && !nxt_s.cke) begin
               nxt_s.st = SDMR5_LK_SAVE;
            end else if (!s_ff.cke && cke) begin
               nxt_s.st = SDMR5_LK_RUN;
            end
         end
         default: begin
            if (take && s_ff.mode_register_set_cmd) begin
               if (s_ff.w[`SDMR5_SEL_HI:`SDMR5_SEL_LO] == `SDMR5_SEL_PREV) begin
                  nxt_s.cal = s_ff.w[`SDMR5_CAL_HI:`SDMR5_CAL_LO];
                  if (s_ff.w[`SDMR5_P_SAVE]) begin
                     nxt_s.st = SDMR5_LK_SAVE;
                  end
               end
               if (s_ff.w[`SDMR5_SEL_HI:`SDMR5_SEL_LO] == `SDMR5_SEL_PREV
                   || s_ff.w[`SDMR5_SEL_HI:`SDMR5_SEL_LO] == `SDMR5_SEL_OPT) begin
                  nxt_s.out = s_ff.w;
                  nxt_s.tgl = !s_ff.tgl;
               end
            end
         end
      endcase
   end
   always_ff @(posedge ck or negedge rst_n) begin
      if (!rst_n) begin
         s_ff <= '{cke: 1'b0, cs: 1'b0, mode_register_set_cmd: 1'b0, w: '0, cs_line: '0, cal: 3'h0,
                   st: SDMR5_LK_RUN, out: '0, tgl: 1'b0};
      end else begin
         s_ff <= nxt_s;
      end
   end
   assign xf.word = s_ff.out;
   assign xf.tgl = s_ff.tgl;
   assign xf.save = (s_ff.st == SDMR5_LK_SAVE);
endmodule
`default_nettype wire

// ---- src/sdmr5_top.sv ----
// sdmr5_top: inversion, mask, termination, parity options register and its feature flags
// assumes CK is the command clock from the controller, MCLK the core clock, error events on MCLK
`timescale 1ns/1ps
`default_nettype none
`include "sdmr5_map.svh"
module sdmr5_top import sdmr5_pkg::*; #(
   parameter int SYNC_STAGES = 2
) (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic CK,
   input wire logic CKE,
   input wire logic CS_N,
   input wire logic ACT_N,
   input wire logic RAS_N,
   input wire logic CAS_N,
   input wire logic WE_N,
   input wire logic [3:0] BG_BA,
   input wire logic [17:0] ADDR,
   input wire logic WIDTH_X4,
   input wire logic READOUT_ACTIVE,
   input wire logic TERM_STROBE_EN,
   input wire logic PARITY_ERR_EVT,
   input wire logic CRC_ERR_EVT,
   output logic [`SDMR5_REG_W-1:0] OPT_READBACK,
   output logic READ_INV_EN,
   output logic WRITE_INV_EN,
   output logic WRITE_MASK_EN,
   output logic [1:0] LANE_PIN_FUNC,
   output logic [2:0] PARKED_TERM_DIV,
   output logic TERM_BUF_PD_OFF,
   output logic PARITY_ERR_STATUS,
   output logic CRC_ERR_STATUS,
   output logic [2:0] PARITY_LATENCY,
   output logic PARITY_CHECK_EN,
   output logic PREAMBLE_TRAIN,
   output logic REFRESH_SKIP_EN,
   output logic REFRESH_EXT_RANGE,
   output logic REF_MONITOR_DRIVE,
   output logic POWER_SAVE
);
   sdmr5_xfer_if xf ();
   logic [3:0] sync_q;
   typedef struct packed {
      logic seen;
      sdmr5_reg_t opt;
      logic perr;
      logic cerr;
      logic train;
      logic tcr;
      logic trng;
      logic vref;
      logic save;
      logic rd_inv;
      logic wr_inv;
      logic mask;
      sdmr5_pin_t pin;
      logic [2:0] park;
      logic [2:0] plat;
      logic pchk;
   } sdmr5_core_t;
   sdmr5_core_t s_ff, nxt_s;

   initial begin
      if (SYNC_STAGES < 2) begin
         $error("sdmr5_top: at least two synchroniser stages");
      end
   end

   sdmr5_link #(
      .CAL_DEPTH(`SDMR5_CAL_MAX)
   ) u_link (
      .ck(CK),
      .rst_n(RST_N),
      .cke(CKE),
      .cs_n(CS_N),
      .act_n(ACT_N),
      .ras_n(RAS_N),
      .cas_n(CAS_N),
      .we_n(WE_N),
      .bgba(BG_BA),
      .addr(ADDR),
      .xf(xf.link)
   );

   // toggle, save level and loose pins into the core clock
   sdmr5_sync #(
      .WIDTH(4),
      .STAGES(SYNC_STAGES)
   ) u_sync (
      .clk(MCLK),
      .rst_n(RST_N),
      .d({xf.tgl, xf.save, WIDTH_X4, READOUT_ACTIVE}),
      .q(sync_q)
   );

   // parked termination divisor, zero when off
   function automatic logic [2:0] park_div(input logic [2:0] c);
      case (c)
         3'h1: park_div = 3'h4;
         3'h2: park_div = 3'h2;
         3'h3: park_div = 3'h6;
         3'h4: park_div = 3'h1;
         3'h5: park_div = 3'h5;
         3'h6: park_div = 3'h3;
         3'h7: park_div = 3'h7;
         default: park_div = 3'h0;
      endcase
   endfunction

   // parity latency in clocks, reserved codes disable
   function automatic logic [2:0] par_lat(input logic [2:0] c);
      case (c)
         3'h1: par_lat = 3'h4;
         3'h2: par_lat = 3'h5;
         3'h3: par_lat = 3'h6;
         default: par_lat = 3'h0;
      endcase
   endfunction

   always_comb begin
      logic tgl_s;
      logic save_s;
      logic x4_s;
      logic ro_s;
      logic fresh;
      sdmr5_word_t w;
      tgl_s = sync_q[3];
      save_s = sync_q[2];
      x4_s = sync_q[1];
      ro_s = sync_q[0];
      w = xf.word;
      nxt_s = s_ff;
      fresh = (tgl_s != s_ff.seen);
      nxt_s.seen = tgl_s;
      // save flag follows the link state
      nxt_s.save = save_s;
      if (fresh && w[`SDMR5_SEL_HI:`SDMR5_SEL_LO] == `SDMR5_SEL_PREV) begin
         nxt_s.train = w[`SDMR5_P_TRAIN];
         nxt_s.tcr = w[`SDMR5_P_TCR];
         nxt_s.trng = w[`SDMR5_P_TRNG];
         nxt_s.vref = w[`SDMR5_P_VREF];
      end
      if (fresh && w[`SDMR5_SEL_HI:`SDMR5_SEL_LO] == `SDMR5_SEL_OPT) begin
         nxt_s.opt = w[`SDMR5_REG_W-1:0] & `SDMR5_WRITABLE;
      end
      // sticky, cleared by a written zero
      nxt_s.perr = s_ff.perr;
      nxt_s.cerr = s_ff.cerr;
      if (fresh && w[`SDMR5_SEL_HI:`SDMR5_SEL_LO] == `SDMR5_SEL_OPT) begin
         nxt_s.perr = s_ff.perr & w[`SDMR5_B_PERR];
         nxt_s.cerr = s_ff.cerr & w[`SDMR5_B_CERR];
      end
      // events set status, parity only while checking is on, set beats clear
      if (PARITY_ERR_EVT && s_ff.pchk) begin
         nxt_s.perr = 1'b1;
      end
      if (CRC_ERR_EVT) begin
         nxt_s.cerr = 1'b1;
      end
      // inversion enables, none at 4 bit, read inversion not during readout
      nxt_s.rd_inv = nxt_s.opt[`SDMR5_B_RD_INV] && !x4_s && !ro_s;
      nxt_s.wr_inv = nxt_s.opt[`SDMR5_B_WR_INV] && !x4_s;
      nxt_s.mask = nxt_s.opt[`SDMR5_B_MASK] && !x4_s;
      if (TERM_STROBE_EN && !x4_s) begin
         nxt_s.pin = SDMR5_PIN_TSTRB;
      end else if (nxt_s.mask) begin
         nxt_s.pin = SDMR5_PIN_MASK;
      end else if (nxt_s.rd_inv || nxt_s.wr_inv) begin
         nxt_s.pin = SDMR5_PIN_INV;
      end else begin
         nxt_s.pin = SDMR5_PIN_NONE;
      end
      nxt_s.park = park_div(nxt_s.opt[`SDMR5_PARK_HI:`SDMR5_PARK_LO]);
      nxt_s.plat = par_lat(nxt_s.opt[`SDMR5_PLAT_HI:`SDMR5_PLAT_LO]);
      // checking halts on error unless persistent
      nxt_s.pchk = (nxt_s.plat != 3'h0) && (nxt_s.opt[`SDMR5_B_PERSIST] || !nxt_s.perr);
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         s_ff <= '{seen: 1'b0, opt: `SDMR5_OPT_RESET, perr: 1'b0, cerr: 1'b0, train: 1'b0,
                   tcr: 1'b0, trng: 1'b0, vref: 1'b0, save: 1'b0, rd_inv: 1'b0, wr_inv: 1'b0,
                   mask: 1'b0, pin: SDMR5_PIN_NONE, park: 3'h0, plat: 3'h0, pchk: 1'b0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   // status bits appear in the readback word
   always_comb begin
      OPT_READBACK = s_ff.opt;
      OPT_READBACK[`SDMR5_B_PERR] = s_ff.perr;
      OPT_READBACK[`SDMR5_B_CERR] = s_ff.cerr;
   end
   assign READ_INV_EN = s_ff.rd_inv;
   assign WRITE_INV_EN = s_ff.wr_inv;
   assign WRITE_MASK_EN = s_ff.mask;
   assign LANE_PIN_FUNC = s_ff.pin;
   assign PARKED_TERM_DIV = s_ff.park;
   assign TERM_BUF_PD_OFF = s_ff.opt[`SDMR5_B_TBUF];
   assign PARITY_ERR_STATUS = s_ff.perr;
   assign CRC_ERR_STATUS = s_ff.cerr;
   assign PARITY_LATENCY = s_ff.plat;
   assign PARITY_CHECK_EN = s_ff.pchk;
   assign PREAMBLE_TRAIN = s_ff.train;
   assign REFRESH_SKIP_EN = s_ff.tcr;
   assign REFRESH_EXT_RANGE = s_ff.trng;
   assign REF_MONITOR_DRIVE = s_ff.vref;
   assign POWER_SAVE = s_ff.save;
endmodule
`default_nettype wire

// ---- test/sdmr5_checker.sv ----
// sdmr5_checker: port properties of the option register block
// assumes outputs registered on MCLK, level inputs behind a short synchroniser
`timescale 1ns/1ps
`default_nettype none
module sdmr5_checker import sdmr5_pkg::*; #(
   parameter int SYNC_STAGES = 2
) (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic WIDTH_X4,
   input wire logic READOUT_ACTIVE,
   input wire logic TERM_STROBE_EN,
   input wire logic PARITY_ERR_EVT,
   input wire logic [17:0] OPT_READBACK,
   input wire logic READ_INV_EN,
   input wire logic WRITE_INV_EN,
   input wire logic WRITE_MASK_EN,
   input wire logic [1:0] LANE_PIN_FUNC,
   input wire logic [2:0] PARKED_TERM_DIV,
   input wire logic TERM_BUF_PD_OFF,
   input wire logic PARITY_ERR_STATUS,
   input wire logic CRC_ERR_STATUS,
   input wire logic [2:0] PARITY_LATENCY,
   input wire logic PARITY_CHECK_EN,
   input wire logic POWER_SAVE
);
   localparam logic [23:0] DIVS = 24'hEE9CA0;
   localparam logic [15:0] LATS = 16'h6540;
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   chk_rdinv_bit: assert property (
      (!WIDTH_X4 && !READOUT_ACTIVE && $stable(OPT_READBACK))[*5] |-> READ_INV_EN == OPT_READBACK[12])
      else $error("read inversion off stored bit");
   chk_wr_bits: assert property (
      (!WIDTH_X4 && $stable(OPT_READBACK))[*5] |-> {WRITE_INV_EN, WRITE_MASK_EN} == OPT_READBACK[11:10])
      else $error("write inversion or mask off stored bit");
   chk_x4_gate: assert property (WIDTH_X4[*5] |-> !(READ_INV_EN || WRITE_INV_EN || WRITE_MASK_EN))
      else $error("lane function on narrow part");
   chk_readout_gate: assert property (READOUT_ACTIVE[*5] |-> !READ_INV_EN)
      else $error("read inversion during readout");
   chk_pin_tstrb: assert property ((TERM_STROBE_EN && !WIDTH_X4)[*5] |-> LANE_PIN_FUNC == SDMR5_PIN_TSTRB)
      else $error("lane pin not termination strobe");
   chk_park_div: assert property (
      $stable(OPT_READBACK)[*3] |-> PARKED_TERM_DIV == DIVS[OPT_READBACK[8:6] * 3 +: 3])
      else $error("parked divisor wrong");
   chk_lat_map: assert property (
      ($stable(OPT_READBACK) && !OPT_READBACK[2])[*3] |-> PARITY_LATENCY == LATS[OPT_READBACK[1:0] * 4 +: 3])
      else $error("parity latency wrong");
   chk_status_bits: assert property (
      $stable(OPT_READBACK)[*3] |-> {TERM_BUF_PD_OFF, PARITY_ERR_STATUS, CRC_ERR_STATUS} == OPT_READBACK[5:3])
      else $error("buffer or status off stored bits");
   chk_perr_set: assert property (PARITY_ERR_EVT && PARITY_CHECK_EN |-> ##[1:3] PARITY_ERR_STATUS)
      else $error("parity error not recorded");
   chk_check_gate: assert property (
      (OPT_READBACK[2:0] == 3'h0 || PARITY_ERR_STATUS && !OPT_READBACK[9])[*3] |-> !PARITY_CHECK_EN)
      else $error("parity checking not stopped");
   chk_save_hold: assert property (
      POWER_SAVE[*2] |-> $stable(OPT_READBACK[12:5]) && !($past(PARITY_ERR_STATUS) && !PARITY_ERR_STATUS))
      else $error("register changed in power saving");
   chk_rsvd_zero: assert property (OPT_READBACK[17:13] == 5'h00)
      else $error("reserved bit stored as one");
endmodule
bind sdmr5_top sdmr5_checker #(.SYNC_STAGES(SYNC_STAGES)) chk (.MCLK, .RST_N, .WIDTH_X4, .READOUT_ACTIVE,
   .TERM_STROBE_EN, .PARITY_ERR_EVT, .OPT_READBACK, .READ_INV_EN, .WRITE_INV_EN, .WRITE_MASK_EN, .LANE_PIN_FUNC,
   .PARKED_TERM_DIV, .TERM_BUF_PD_OFF, .PARITY_ERR_STATUS, .CRC_ERR_STATUS, .PARITY_LATENCY, .PARITY_CHECK_EN,
   .POWER_SAVE);
`default_nettype wire

// ---- test/sdmr5_ctrl_model.sv ----
// sdmr5_ctrl_model: memory controller issuing mode register set commands
// assumes ck is the command clock; released pins show the inverted last word
`timescale 1ns/1ps
`default_nettype none
module sdmr5_ctrl_model (
   input wire logic ck,
   output logic cke,
   output logic cs_n,
   output logic act_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [3:0] bg_ba,
   output logic [17:0] addr
);
   logic [21:0] last_w = 22'h000000;

   task automatic park();
      cs_n <= 1'b1;
      act_n <= 1'b1;
      ras_n <= 1'b1;
      cas_n <= 1'b1;
      we_n <= 1'b1;
      bg_ba <= ~last_w[21:18];
      addr <= ~last_w[17:0];
   endtask

   initial begin
      cke <= 1'b1;
      park();
   end

   // planar part, gear-down off: inversion and code 010 legal
   task automatic issue(input logic [21:0] w, input int cal);
      logic [21:0] v;
      v = w & 22'h1DDFFF;
      @(posedge ck);
      last_w <= v;
      cs_n <= 1'b0;
      ras_n <= 1'b0;
      cas_n <= 1'b0;
      we_n <= 1'b0;
      bg_ba <= v[21:18];
      addr <= {v[17], 3'h0, v[13:0]};
      @(posedge ck);
      cs_n <= 1'b1;
      repeat (cal + 1) @(posedge ck);
      park();
   endtask

   task automatic wake();
      @(posedge ck);
      cke <= 1'b0;
      repeat (2) @(posedge ck);
      cke <= 1'b1;
   endtask
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// tb_top: drives the option register block with mode register set commands
// assumes the controller model owns the command pins
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic mclk = 1'b0;
   logic ck = 1'b0;
   logic rst_n = 1'b0;
   logic x4 = 1'b0, ro = 1'b0, tse = 1'b0, pev = 1'b0, cev = 1'b0;
   logic cke, cs_n, act_n, ras_n, cas_n, we_n;
   logic [3:0] bg_ba;
   logic [17:0] addr, rb;
   logic rdi, wri, wme, tbo, pst, cst, pce, ptr, rse, rer, rmd, psv;
   logic [1:0] lpf;
   logic [2:0] ptd, plt;
   int err_count = 0;
   int checks_done = 0;
   int cycles = 0;
   int cal = 0;
   logic [17:0] img = 18'h00000;
   logic [17:0] f4 = 18'h00000;
   logic [23:0] cals = 24'h865430;
   logic [23:0] divs = 24'hEE9CA0;
   logic [31:0] lats = 32'h00006540;

   sdmr5_ctrl_model ctrl (.ck, .cke, .cs_n, .act_n, .ras_n, .cas_n, .we_n, .bg_ba, .addr);
   sdmr5_top dut (.MCLK(mclk), .RST_N(rst_n), .CK(ck), .CKE(cke), .CS_N(cs_n), .ACT_N(act_n), .RAS_N(ras_n),
      .CAS_N(cas_n), .WE_N(we_n), .BG_BA(bg_ba), .ADDR(addr), .WIDTH_X4(x4), .READOUT_ACTIVE(ro),
      .TERM_STROBE_EN(tse), .PARITY_ERR_EVT(pev), .CRC_ERR_EVT(cev), .OPT_READBACK(rb), .READ_INV_EN(rdi),
      .WRITE_INV_EN(wri), .WRITE_MASK_EN(wme), .LANE_PIN_FUNC(lpf), .PARKED_TERM_DIV(ptd), .TERM_BUF_PD_OFF(tbo),
      .PARITY_ERR_STATUS(pst), .CRC_ERR_STATUS(cst), .PARITY_LATENCY(plt), .PARITY_CHECK_EN(pce),
      .PREAMBLE_TRAIN(ptr), .REFRESH_SKIP_EN(rse), .REFRESH_EXT_RANGE(rer), .REF_MONITOR_DRIVE(rmd),
      .POWER_SAVE(psv));

   always #5 mclk = ~mclk;
   always #80 ck = ~ck;

   task automatic close_out();
      if (err_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         close_out();
      end
   end

   task automatic chk(input string n, input logic [17:0] e, input logic [17:0] g);
      checks_done++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", n, e, g);
         err_count++;
      end
   endtask

   task automatic wr(input logic [2:0] sel, input logic [17:0] d, input logic hit);
      ctrl.issue({1'b0, sel, d}, cal);
      repeat (3) @(posedge ck);
      if (hit && sel == 3'h5) begin
         img = (d & 18'h01FE7) | (img & d & 18'h00018);
      end else if (hit && sel == 3'h4) begin
         f4 = d;
         cal = int'(cals[d[8:6] * 4 +: 4]);
      end
   endtask

   task automatic all();
      logic ri, wi, mk, pe;
      logic [2:0] lt;
      ri = img[12] & ~x4 & ~ro;
      wi = img[11] & ~x4;
      mk = img[10] & ~x4;
      lt = lats[img[2:0] * 4 +: 3];
      pe = (lt != 3'h0) & (~img[4] | img[9]);
      chk("readback", img, rb);
      chk("flags", 18'({ri, wi, mk, img[5:3], pe}), 18'({rdi, wri, wme, tbo, pst, cst, pce}));
      chk("feat", 18'({f4[10], f4[4:1]}), 18'({ptr, rmd, rse, rer, psv}));
      chk("plat", 18'(lt), 18'(plt));
      chk("lane", 18'((tse & ~x4) ? 2'h3 : mk ? 2'h1 : (ri | wi) ? 2'h2 : 2'h0), 18'(lpf));
      chk("park", 18'(divs[img[8:6] * 3 +: 3]), 18'(ptd));
   endtask

   task automatic pulse(input logic p, input logic c);
      img[4] = img[4] | (p & (lats[img[2:0] * 4 +: 3] != 3'h0) & (~img[4] | img[9]));
      img[3] = img[3] | c;
      @(posedge mclk);
      pev <= p;
      cev <= c;
      @(posedge mclk);
      pev <= 1'b0;
      cev <= 1'b0;
      repeat (4) @(posedge mclk);
      all();
   endtask

   initial begin
      repeat (8) @(posedge ck);
      rst_n <= 1'b1;
      repeat (2) @(posedge ck);
      all();
      for (int i = 0; i < 8; i++) begin
         @(posedge mclk);
         tse <= (i == 5);
         wr(3'h5, {5'h00, i[0], i[1] & ~i[2], i[2], i[1], i[2:0], i[0], 2'h3, 1'b0, i[1:0]}, 1'b1);
         all();
      end
      tse <= 1'b0;
      wr(3'h6, 18'h3FFFF, 1'b0);
      wr(3'h4, 18'h0041C, 1'b1);
      all();
      wr(3'h5, 18'h00001, 1'b1);
      pulse(1'b1, 1'b1);
      pulse(1'b1, 1'b0);
      wr(3'h5, 18'h00019, 1'b1);
      all();
      wr(3'h5, 18'h00201, 1'b1);
      pulse(1'b1, 1'b0);
      wr(3'h5, 18'h00000, 1'b1);
      pulse(1'b1, 1'b0);
      wr(3'h5, 18'h00006, 1'b1);
      pulse(1'b1, 1'b0);
      wr(3'h5, 18'h01800, 1'b1);
      @(posedge mclk);
      x4 <= 1'b1;
      repeat (8) @(posedge mclk);
      all();
      x4 <= 1'b0;
      ro <= 1'b1;
      repeat (8) @(posedge mclk);
      all();
      ro <= 1'b0;
      for (int c = 1; c < 6; c++) begin
         wr(3'h4, 18'(c << 6), 1'b1);
         ctrl.issue({4'h5, 18'(c)}, 0);
         repeat (cal + 3) @(posedge ck);
         all();
         wr(3'h5, 18'(c << 6), 1'b1);
         all();
      end
      wr(3'h4, 18'h00002, 1'b1);
      all();
      wr(3'h5, 18'h01000, 1'b0);
      all();
      ctrl.wake();
      f4[1] = 1'b0;
      repeat (3) @(posedge ck);
      all();
      wr(3'h5, 18'h01000, 1'b1);
      all();
      rst_n <= 1'b0;
      repeat (3) @(posedge ck);
      rst_n <= 1'b1;
      img = 18'h00000;
      f4 = 18'h00000;
      cal = 0;
      repeat (2) @(posedge ck);
      all();
      close_out();
   end
endmodule
`default_nettype wire
